// File: core/fst_drive.sv
`include "fst_params.svh"

// Contract
// - Torque-limit-active is closed while the output torque is clamped.
// - Torque-limit-active reaches its terminal only once allocated.
// - Encoder usage digit after power-up: 0 as built, 1 incremental, 2 one-turn.
// - Forced-stop input closed lets the drive run; open makes it stop.
// - The forced-stop input acts only once allocated to a terminal.
// - A forced-stop indication is shown while the forced stop is active.
// - Method 0 stops by dynamic brake or coasting per servo-off setting.
// - Method 1 decelerates at stop torque, then the servo-off stop state.
// - Method 2 decelerates at stop torque, then coasts.
// - Method 3 ramps over the decel time, then the servo-off stop state.
// - Method 4 ramps over the decel time, then coasts.
// - In torque control mode no decelerating stop is used.
// - Stop torque is 0 to 800 percent, default 800, capped at motor max.
// - A decel time of zero gives an immediate zero-speed stop.
// - Decel time 0 to 10000 ms spans top speed to standstill, fixed slope.
// - Servo-on while input open keeps the stop latched until servo-off; in method 0 or torque mode servo-off never clears it.
module fst_drive
    import fst_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic forced_stop_in_i,
    input wire logic torque_clamped_i,
    input wire logic [15:0] speed_i,
    input wire logic [7:0] setup_strap_i,
    output logic torque_limit_active_out_o,
    output logic forced_stop_display_o,
    output logic dynamic_brake_o,
    output logic coast_o,
    output logic [9:0] stop_torque_limit_o,
    output logic [15:0] speed_ref_o,
    output logic stop_ref_valid_o
);

    ////////////////////////////////////////////////////////////////////
    logic fs_sync;
    logic srv_on_r;
    logic trq_mode_r;
    logic soff_coast_r;
    logic out_alloc_r;
    logic fs_alloc_r;
    logic [9:0] estop_trq_r;
    logic [13:0] decel_r;
    logic [2:0] method_r;
    fst_enc_t enc_r;
    logic setup_done_r;
    logic latched_r;
    logic bb_r;
    fst_state_t state_r;
    fst_state_t state_nxt;
    logic [16:0] ms_cnt_r;
    logic [31:0] step_acc_r;
    logic [15:0] speed_ref_r;
    logic fs_open;
    logic stop_req;
    logic wb_hit;
    logic [31:0] rd_data;

    fst_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(forced_stop_in_i),
        .q_o(fs_sync)
    );

    // Unallocated input reads as closed so the drive runs normally
    assign fs_open = fs_alloc_r & ~fs_sync;
    assign stop_req = fs_open | latched_r;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack drops the cycle after
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srv_on_r <= 1'b0;
            trq_mode_r <= 1'b0;
            soff_coast_r <= 1'b0;
            out_alloc_r <= 1'b0;
            fs_alloc_r <= 1'b0;
            estop_trq_r <= `FST_ESTOP_TRQ_RST;
            decel_r <= `FST_DECEL_RST;
        end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `FST_OFF_CTRL: begin
                    srv_on_r <= wb_dat_i[`FST_CTRL_SRV_ON];
                    trq_mode_r <= wb_dat_i[`FST_CTRL_TRQ_MODE];
                    soff_coast_r <= wb_dat_i[`FST_CTRL_SOFF_COAST];
                end
                `FST_OFF_ALLOC: begin
                    out_alloc_r <= wb_dat_i[0];
                    fs_alloc_r <= wb_dat_i[4];
                end
                `FST_OFF_ESTOP_TRQ: begin
                    if (wb_sel_i[1]) begin
                        // Out-of-range writes saturate at the top
                        if (wb_dat_i[9:0] > `FST_ESTOP_TRQ_MAX) begin
                            estop_trq_r <= `FST_ESTOP_TRQ_MAX;
                        end else begin
                            estop_trq_r <= wb_dat_i[9:0];
                        end
                    end
                end
                `FST_OFF_DECEL: begin
                    if (wb_sel_i[1]) begin
                        if (wb_dat_i[13:0] > `FST_DECEL_MAX) begin
                            decel_r <= `FST_DECEL_MAX;
                        end else begin
                            decel_r <= wb_dat_i[13:0];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `FST_OFF_CTRL: begin
                rd_data[`FST_CTRL_SRV_ON] = srv_on_r;
                rd_data[`FST_CTRL_TRQ_MODE] = trq_mode_r;
                rd_data[`FST_CTRL_SOFF_COAST] = soff_coast_r;
            end
            `FST_OFF_ALLOC: begin
                rd_data[0] = out_alloc_r;
                rd_data[4] = fs_alloc_r;
            end
            `FST_OFF_ESTOP_TRQ: rd_data[9:0] = estop_trq_r;
            `FST_OFF_DECEL: rd_data[13:0] = decel_r;
            `FST_OFF_STATUS: begin
                rd_data[`FST_ST_FSTOP] = forced_stop_display_o;
                rd_data[`FST_ST_TLIM] = torque_limit_active_out_o;
                rd_data[`FST_ST_DBRAKE] = dynamic_brake_o;
                rd_data[`FST_ST_COAST] = coast_o;
                rd_data[`FST_ST_DECEL] = stop_ref_valid_o;
                rd_data[`FST_ST_BB] = bb_r;
                rd_data[`FST_ST_ENC_LSB +: 2] = enc_r;
            end
            `FST_OFF_SETUP: begin
                rd_data[`FST_SETUP_METHOD_LSB +: 3] = method_r;
                rd_data[`FST_SETUP_ENC_LSB +: 2] = enc_r;
            end
            `FST_OFF_SPEED: rd_data[15:0] = speed_ref_r;
            `FST_OFF_TORQUE: rd_data[9:0] = stop_torque_limit_o;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Setup digits take effect only after a restart, so they are caught
    // once after reset release and never follow the strap afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_done_r <= 1'b0;
            method_r <= `FST_METHOD_RST;
            enc_r <= FST_ENC_AS_BUILT;
        end else if (!setup_done_r) begin
            setup_done_r <= 1'b1;
            if (setup_strap_i[2:0] > 3'd4) begin
                method_r <= `FST_METHOD_RST;
            end else begin
                method_r <= setup_strap_i[2:0];
            end
            case (setup_strap_i[5:4])
                2'h1: enc_r <= FST_ENC_INCREMENTAL;
                2'h2: enc_r <= FST_ENC_SINGLE_TURN;
                default: enc_r <= FST_ENC_AS_BUILT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stop latch: servo-on while open sticks; only servo-off in RUN or STOPPED clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_r <= 1'b0;
        end else if (srv_on_r && fs_open) begin
            latched_r <= 1'b1;
        end else if (!srv_on_r && bb_r) begin
            latched_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bb_r <= 1'b1;
        end else begin
            bb_r <= !srv_on_r && (state_r == FST_RUN
                    || state_r == FST_STOPPED);
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FST_RUN: begin
                if (stop_req) begin
                    if (trq_mode_r || method_r == 3'd0) begin
                        state_nxt = FST_STOP_BRAKE;
                    end else if (method_r <= 3'd2) begin
                        state_nxt = FST_STOP_TORQUE;
                    end else if (decel_r == 14'd0) begin
                        state_nxt = FST_STOPPED;
                    end else begin
                        state_nxt = FST_STOP_RAMP;
                    end
                end
            end
            FST_STOP_TORQUE: begin
                if (speed_i == 16'h0000) begin
                    state_nxt = FST_STOPPED;
                end
            end
            FST_STOP_RAMP: begin
                if (speed_ref_r == 16'h0000) begin
                    state_nxt = FST_STOPPED;
                end
            end
            FST_STOP_BRAKE, FST_STOPPED: begin
                if (!stop_req) begin
                    state_nxt = FST_RUN;
                end
            end
            default: state_nxt = FST_RUN;
        endcase
        if (state_r != FST_RUN && state_r != FST_STOPPED
                && state_r != FST_STOP_BRAKE && !stop_req) begin
            state_nxt = FST_RUN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= FST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ramp: slope fixed as top speed per decel time; the accumulator
    // adds top speed each ms, then pays out one speed unit per clock for
    // every whole decel time it holds, so steep ramps still keep pace
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_r <= 17'd0;
            step_acc_r <= 32'h0000_0000;
            speed_ref_r <= 16'h0000;
        end else if (state_r != FST_STOP_RAMP) begin
            ms_cnt_r <= 17'd0;
            step_acc_r <= 32'h0000_0000;
            speed_ref_r <= speed_i;
        end else if (ms_cnt_r == 17'(`FST_MS_CYCLES - 1)) begin
            ms_cnt_r <= 17'd0;
            step_acc_r <= step_acc_r + 32'(`FST_TOP_SPEED);
        end else begin
            ms_cnt_r <= ms_cnt_r + 17'd1;
            if (decel_r != 14'd0 && step_acc_r >= 32'(decel_r)) begin
                // Whole steps only; the remainder carries over
                step_acc_r <= step_acc_r - 32'(decel_r);
                if (speed_ref_r == 16'h0000) begin
                    speed_ref_r <= 16'h0000;
                end else begin
                    speed_ref_r <= speed_ref_r - 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            torque_limit_active_out_o <= 1'b0;
            forced_stop_display_o <= 1'b0;
            dynamic_brake_o <= 1'b0;
            coast_o <= 1'b0;
            stop_torque_limit_o <= `FST_MOTOR_MAX_TRQ;
            speed_ref_o <= 16'h0000;
            stop_ref_valid_o <= 1'b0;
        end else begin
            torque_limit_active_out_o <= out_alloc_r
                    & torque_clamped_i;
            forced_stop_display_o <= stop_req
                    || state_r != FST_RUN;
            dynamic_brake_o <= (state_r == FST_STOP_BRAKE
                    || state_r == FST_STOPPED) && !soff_coast_r
                    && !(state_r == FST_STOPPED
                    && (method_r == 3'd2 || method_r == 3'd4));
            coast_o <= (state_r == FST_STOP_BRAKE
                    || state_r == FST_STOPPED) && (soff_coast_r
                    || (state_r == FST_STOPPED && (method_r == 3'd2
                    || method_r == 3'd4)));
            if (estop_trq_r > `FST_MOTOR_MAX_TRQ) begin
                stop_torque_limit_o <= `FST_MOTOR_MAX_TRQ;
            end else begin
                stop_torque_limit_o <= estop_trq_r;
            end
            speed_ref_o <= speed_ref_r;
            stop_ref_valid_o <= (state_r == FST_STOP_RAMP);
        end
    end
endmodule

// File: core/fst_params.svh
`ifndef FST_PARAMS_SVH
`define FST_PARAMS_SVH

// Wishbone register byte offsets
`define FST_OFF_CTRL      8'h00
`define FST_OFF_ALLOC     8'h04
`define FST_OFF_ESTOP_TRQ 8'h08
`define FST_OFF_DECEL     8'h0C
`define FST_OFF_STATUS    8'h10
`define FST_OFF_SETUP     8'h14
`define FST_OFF_SPEED     8'h18
`define FST_OFF_TORQUE    8'h1C

// Control register fields
`define FST_CTRL_SRV_ON   0
`define FST_CTRL_TRQ_MODE 1
`define FST_CTRL_SOFF_COAST 2

// Setup register fields (latched at power-up)
`define FST_SETUP_METHOD_LSB 0
`define FST_SETUP_ENC_LSB    4

// Status register fields
`define FST_ST_FSTOP     0
`define FST_ST_TLIM      1
`define FST_ST_DBRAKE    2
`define FST_ST_COAST     3
`define FST_ST_DECEL     4
`define FST_ST_ENC_LSB   8
`define FST_ST_BB        5

// Reset values, limits and ramp scale
`define FST_ESTOP_TRQ_RST 10'd800
`define FST_ESTOP_TRQ_MAX 10'd800
`define FST_DECEL_RST     14'd0
`define FST_DECEL_MAX     14'd10000
`define FST_METHOD_RST    3'd1
`define FST_ENC_RST       2'd0
`define FST_MOTOR_MAX_TRQ 10'd300
`define FST_TOP_SPEED     16'd6000

// Timing: one decel time unit is 1 ms at 100 MHz
`define FST_CLK_MHZ      100
`define FST_DECEL_UNIT_US 1000
`define FST_MS_CYCLES    (`FST_CLK_MHZ * `FST_DECEL_UNIT_US)

`endif

// File: core/fst_pkg.sv
package fst_pkg;
    typedef enum logic [1:0] {
        FST_ENC_AS_BUILT,
        FST_ENC_INCREMENTAL,
        FST_ENC_SINGLE_TURN
    } fst_enc_t;
    typedef enum {
        FST_RUN,
        FST_STOP_BRAKE,
        FST_STOP_TORQUE,
        FST_STOP_RAMP,
        FST_STOPPED
    } fst_state_t;
endpackage

// File: core/fst_sync.sv
// Three-stage synchroniser; a change is accepted once stages two and three agree
module fst_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (s2_r == s3_r) begin
            q_o <= s3_r;
        end
    end
endmodule

// File: bench/fst_drive_properties.sv
module fst_drive_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic forced_stop_in_i,
    input wire logic torque_clamped_i,
    input wire logic torque_limit_active_out_o,
    input wire logic forced_stop_display_o,
    input wire logic dynamic_brake_o,
    input wire logic coast_o,
    input wire logic [9:0] stop_torque_limit_o,
    input wire logic [15:0] speed_ref_o,
    input wire logic stop_ref_valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    property p_ack_bound;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_tlim;
        !$past(torque_clamped_i) |-> !torque_limit_active_out_o;
    endproperty
    a_tlim: assert property (p_tlim) else $error("flag without clamp");
    property p_cap;
        stop_torque_limit_o <= 10'h12C;
    endproperty
    a_cap: assert property (p_cap) else $error("stop torque over cap");
    property p_excl;
        !(dynamic_brake_o && coast_o);
    endproperty
    a_excl: assert property (p_excl) else $error("brake and coast");
    property p_ramp;
        stop_ref_valid_o |-> !dynamic_brake_o && !coast_o;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp with brake");
    property p_ramp_down;
        stop_ref_valid_o && $past(stop_ref_valid_o)
            |-> speed_ref_o <= $past(speed_ref_o);
    endproperty
    a_ramp_down: assert property (p_ramp_down) else $error("ramp rose");
    // A filtered pin cannot act in the two cycles after it opens
    property p_sync;
        $fell(forced_stop_in_i) && !forced_stop_display_o
            |=> !forced_stop_display_o [*2];
    endproperty
    a_sync: assert property (p_sync) else $error("pin not filtered");
    property p_rise;
        $rose(forced_stop_display_o) |-> !$past(forced_stop_in_i, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("stop without open");
endmodule

// File: bench/fst_host_model.sv
module fst_host_model (
    input wire logic clk_i,
    input wire logic open_i,
    input wire logic clamp_i,
    input wire logic [15:0] speed_set_i,
    output logic forced_stop_in_o = 1'b1,
    output logic torque_clamped_o = 1'b0,
    output logic [15:0] speed_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pin high while closed; opening it asks the drive to stop
    always_ff @(posedge clk_i) begin
        forced_stop_in_o <= !open_i;
        torque_clamped_o <= clamp_i;
        speed_o <= speed_set_i;
    end
endmodule

// File: bench/fst_drive_tb.sv
`include "fst_params.svh"
module fst_drive_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_ack_o, forced_stop_in_i, torque_clamped_i;
    logic [15:0] speed_i, speed_ref_o;
    logic [7:0] setup_strap_i = 8'h07;
    logic torque_limit_active_out_o, forced_stop_display_o;
    logic dynamic_brake_o, coast_o, stop_ref_valid_o;
    logic [9:0] stop_torque_limit_o;
    logic fs_open = 1'b0;
    logic clamp = 1'b0;
    logic [15:0] spd = 16'h0000;
    logic [31:0] q;
    int n_mismatch = 0;
    int cmp_count = 0;
    fst_drive i_dut (.*);
    fst_host_model i_host (.clk_i, .open_i(fs_open), .clamp_i(clamp),
        .speed_set_i(spd), .forced_stop_in_o(forced_stop_in_i),
        .torque_clamped_o(torque_clamped_i), .speed_o(speed_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold until ack, release, idle one cycle
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(a, 1'b0, 32'h0, r);
    endtask
    task automatic wait_disp(input logic e);
        int n;
        n = 0;
        while (forced_stop_display_o !== e && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk(forced_stop_display_o, e);
    endtask
    task automatic do_reset(input logic [7:0] s);
        setup_strap_i <= s;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int e;
        do_reset(8'h07);
        rd(`FST_OFF_ESTOP_TRQ, q); chk(q, 32'h320);
        rd(`FST_OFF_DECEL, q); chk(q, 32'h0);
        rd(`FST_OFF_SETUP, q); chk(q, 32'h1);
        rd(8'h20, q); chk(q, 32'h0);
        chk(stop_torque_limit_o, 32'h12C);
        wr(`FST_OFF_ESTOP_TRQ, 32'h384);
        rd(`FST_OFF_ESTOP_TRQ, q); chk(q, 32'h320);
        wr(`FST_OFF_ESTOP_TRQ, 32'h64);
        repeat (2) @(posedge clk_i);
        chk(stop_torque_limit_o, 32'h64);
        wr(`FST_OFF_DECEL, 32'h2EE0);
        rd(`FST_OFF_DECEL, q); chk(q, 32'h2710);
        wr(`FST_OFF_DECEL, 32'h0);
        clamp <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(torque_limit_active_out_o, 32'h0);
        wr(`FST_OFF_ALLOC, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(torque_limit_active_out_o, 32'h1);
        clamp <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(torque_limit_active_out_o, 32'h0);
        fs_open <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk(forced_stop_display_o, 32'h0);
        wr(`FST_OFF_ALLOC, 32'h11);
        wait_disp(1'b1);
        fs_open <= 1'b0;
        wait_disp(1'b0);
        // Every stop method, encoder digit cycling alongside
        for (int m = 0; m < 5; m++) begin
            e = m % 3;
            do_reset(8'(e * 16 + m));
            rd(`FST_OFF_SETUP, q); chk(q, 32'(e * 16 + m));
            rd(`FST_OFF_STATUS, q); chk(q & 32'h300, 32'(e * 256));
            wr(`FST_OFF_CTRL, (m == 0) ? 32'h4 : 32'h0);
            wr(`FST_OFF_ALLOC, 32'h10);
            fs_open <= 1'b1;
            wait_disp(1'b1);
            repeat (20) @(posedge clk_i);
            chk(coast_o, 32'(m % 2 == 0));
            chk(dynamic_brake_o, 32'(m % 2));
            fs_open <= 1'b0;
            wait_disp(1'b0);
        end
        spd <= 16'h0BB8;
        wr(`FST_OFF_DECEL, 32'h2710);
        fs_open <= 1'b1;
        wait_disp(1'b1);
        repeat (5) @(posedge clk_i);
        chk(stop_ref_valid_o, 32'h1);
        chk(speed_ref_o, 32'h0BB8);
        fs_open <= 1'b0;
        wait_disp(1'b0);
        wr(`FST_OFF_CTRL, 32'h2);
        fs_open <= 1'b1;
        wait_disp(1'b1);
        repeat (5) @(posedge clk_i);
        chk(stop_ref_valid_o, 32'h0);
        chk(dynamic_brake_o, 32'h1);
        fs_open <= 1'b0;
        wait_disp(1'b0);
        spd <= 16'h0000;
        wr(`FST_OFF_CTRL, 32'h1);
        fs_open <= 1'b1;
        wait_disp(1'b1);
        fs_open <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk(forced_stop_display_o, 32'h1);
        wr(`FST_OFF_CTRL, 32'h0);
        wait_disp(1'b0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
bind fst_drive fst_drive_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .forced_stop_in_i, .torque_clamped_i,
    .torque_limit_active_out_o, .forced_stop_display_o, .dynamic_brake_o,
    .coast_o, .stop_torque_limit_o, .speed_ref_o, .stop_ref_valid_o);
